// File: verilog/dcs_regs.vh
`ifndef DCS_REGS_VH
`define DCS_REGS_VH
// --------
// command byte layout
// --------
`define DCS_CMD_GLOBAL_BIT   0
`define DCS_CMD_READ_BIT     1
`define DCS_CMD_CMDSEL_BIT   2
`define DCS_CMD_POLL         8'h57
`define DCS_CMD_SWRESET      8'h5d
// --------
// register pointers
// --------
`define DCS_PTR_TEMP         4'h0
`define DCS_PTR_CFG          4'h1
`define DCS_PTR_EE_FIRST     4'h6
`define DCS_PTR_EE_LAST      4'hd
`define DCS_PTR_DIE_ID       4'hf
// --------
// field positions
// --------
`define DCS_TEMP_UNLOCK_BIT  0
`define DCS_TEMP_BUSY_BIT    1
`define DCS_CFG_RST_BIT      1
`define DCS_CFG_SD_BIT       11
`define DCS_CFG_OS_BIT       12
`define DCS_CFG_FH1_BIT      10
`define DCS_CFG_FL1_BIT      9
`define DCS_CFG_FH2_BIT      6
`define DCS_CFG_FL2_BIT      5
`define DCS_CFG_RD_MASK      16'he998
// --------
// reset values
// --------
`define DCS_CFG_RST_VAL      16'ha000
`define DCS_DIE_ID_VAL       16'h1234
// --------
// timing
// --------
`define DCS_CLK_MHZ          100
`define DCS_EE_PROG_MS       16
`define DCS_TMO_MS           35
`define DCS_EE_RD_US         100
`define DCS_CONV_MS          10
`define DCS_RSP_CYC          868
`endif

// File: verilog/dcs_conv.v
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.vh"

// --------
// conversion scheduler: continuous, shutdown and one-shot
// --------
module dcs_conv #(
  parameter [23:0] CONV_CYC = `DCS_CONV_MS * 1000 * `DCS_CLK_MHZ
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        shutdown,
  input  wire        one_shot,
  input  wire        restart,
  output reg         done_q,
  output wire        active
);
  reg  [23:0] cnt_q;   // cycles into current conversion
  reg         os_q;    // single conversion pending in shutdown
  wire        run;     // converter powered

  // continuous unless shut down; one-shot powers a single run
  assign run    = ~shutdown | os_q;
  assign active = run;

  // --------
  // period counter and result strobe
  // --------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= 24'h000000;
      done_q <= 1'b0;
    end else if (restart || !run) begin
      // mode change aborts the ongoing conversion
      cnt_q  <= 24'h000000;
      done_q <= 1'b0;
    end else if (cnt_q == CONV_CYC - 24'h000001) begin
      cnt_q  <= 24'h000000;
      done_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 24'h000001;
      done_q <= 1'b0;
    end
  end

  // one-shot request, cleared by its own result
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      os_q <= 1'b0;
    end else if (one_shot && shutdown) begin
      os_q <= 1'b1;                                           // [R11]
    end else if (done_q || !shutdown) begin
      os_q <= 1'b0;                                           // [R11]
    end
  end
endmodule // dcs_conv
`default_nettype wire

// File: verilog/dcs_ops.v
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.vh"
// Function
// R1 - last device answers poll with own address
// R2 - only initialization-time last device answers poll
// R3 - reset command reloads eeprom, clears temperature
// R4 - individual write hits only matching address
// R5 - reply starts within one and half baud
// R6 - global write hits addresses up to field
// R7 - global read returns addressed down to first
// R8 - missing device: stall, time out after 35ms
// R9 - continuous conversions update temperature and flags
// R10 - shutdown stops conversions, registers stay accessible
// R11 - one-shot in shutdown runs one conversion
// R12 - one-shot bit always reads zero
// R13 - eight general words at pointers 6h-Dh
// R14 - reset copies eeprom into registers except two
// R15 - eeprom locked after power-up, writes ignored
// R16 - unlock flag bit0 of temperature register
// R17 - eeprom locations readable locked or unlocked
// R18 - unlocked write programs eeprom up to 16ms
// R19 - busy bit high while programming
// R20 - programming blocks writes to other registers
// R21 - global eeprom write programs all in range
// R22 - eeprom read stretches reply by 100us
// R23 - command byte bit layout and codes
// R24 - data sent low byte then high byte
// R25 - intermediate devices pass traffic both ways
// R26 - one-shot in continuous mode changes nothing

module dcs_ops #(
  parameter [21:0] EE_PROG_CYC = `DCS_EE_PROG_MS * 1000 * `DCS_CLK_MHZ,
  parameter [21:0] TMO_CYC     = `DCS_TMO_MS * 1000 * `DCS_CLK_MHZ,
  parameter [21:0] EE_RD_CYC   = `DCS_EE_RD_US * `DCS_CLK_MHZ,
  parameter [21:0] RSP_CYC     = `DCS_RSP_CYC,
  parameter [23:0] CONV_CYC    = `DCS_CONV_MS * 1000 * `DCS_CLK_MHZ,
  parameter [15:0] DIE_ID      = `DCS_DIE_ID_VAL  // arbitrary value
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire [4:0]  my_addr,       // address assigned at initialization
  input  wire        last_at_init,  // was last device at initialization
  input  wire        up_rx_sof,     // new frame on upstream_port
  input  wire        up_rx_valid,   // byte received on upstream_port
  input  wire [7:0]  up_rx_data,
  input  wire        up_tx_ready,   // upstream transmitter free
  output wire        up_tx_valid,
  output reg  [7:0]  up_tx_data_q,
  input  wire        dn_rx_valid,   // byte received on downstream_port
  input  wire [7:0]  dn_rx_data,
  output reg         dn_tx_valid_q,
  output reg  [7:0]  dn_tx_data_q,
  input  wire [13:0] temp_sample,   // converter result
  input  wire [3:0]  alert_flags,   // {fh1, fl1, fh2, fl2}
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata_q,
  output wire        conv_active
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_CMD  = 9'h002;
  localparam [8:0] ST_PTR  = 9'h004;
  localparam [8:0] ST_DLO  = 9'h008;
  localparam [8:0] ST_DHI  = 9'h010;
  localparam [8:0] ST_WAIT = 9'h020;
  localparam [8:0] ST_TXLO = 9'h040;
  localparam [8:0] ST_TXHI = 9'h080;
  localparam [8:0] ST_FWD  = 9'h100;

  reg  [8:0]  st_q;                // transaction state
  reg  [7:0]  cmd_q;               // command and address byte
  reg  [3:0]  ptr_q;               // register pointer
  reg  [7:0]  lo_q;                // write data low byte
  reg  [21:0] cnt_q;               // reply delay / stall timeout
  reg  [5:0]  fwd_n_q;             // bytes still to forward upstream
  reg         own_after_q;         // own word follows forwarded ones
  reg         poll_q;              // reply is a poll answer
  reg         fwd_v_q;             // forwarded byte valid
  reg  [13:0] temp_q;              // temperature result
  reg  [3:0]  alert_q;             // alert flags from last conversion
  reg         unlock_q;            // eeprom_unlock_flag
  reg         busy_q;              // eeprom programming underway
  reg  [21:0] prog_q;              // programming time left
  reg         load_q;              // copy eeprom into registers
  reg  [15:0] regs_q [1:13];       // working registers
  reg  [15:0] ee_q   [1:13];       // nonvolatile store
  wire        conv_done;

  // command fields
  wire        c_glob = cmd_q[`DCS_CMD_GLOBAL_BIT];                 // [R23]
  wire        c_read = cmd_q[`DCS_CMD_READ_BIT];                   // [R23]
  wire [4:0]  c_addr = cmd_q[7:3];                                 // [R23]
  wire [4:0]  a_diff = c_addr - my_addr;
  wire        c_me   = (c_addr == my_addr);
  wire        c_blw  = (my_addr < c_addr);

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  function [15:0] rd_val;
    input [3:0] p;
    begin
      if (p == `DCS_PTR_TEMP)
        rd_val = {temp_q, busy_q, unlock_q};                       // [R19]
      else if (p == `DCS_PTR_CFG)
        // one-shot, reset and flag bits are not stored words
        rd_val = (regs_q[1] & `DCS_CFG_RD_MASK) |
                 {5'h00, alert_q[3], alert_q[2], 2'h0,
                  alert_q[1], alert_q[0], 5'h00};                  // [R12]
      else if (p == `DCS_PTR_DIE_ID)
        rd_val = DIE_ID;
      else if (p < `DCS_PTR_DIE_ID - 4'h1)
        rd_val = regs_q[p];                                        // [R17]
      else
        rd_val = 16'h0000;
    end
  endfunction
  wire [15:0] p_val = rd_val(ptr_q);  // word behind the link pointer
  // ----------------------------------------------------------------
  // write path shared by link and local port
  // ----------------------------------------------------------------
  wire        lk_wr = (st_q == ST_DHI) & up_rx_valid &
                      (c_glob ? c_blw | c_me : c_me);              // [R4] [R6]
  wire        w_go  = lk_wr | reg_wr;
  wire [3:0]  w_ptr = lk_wr ? ptr_q : reg_addr;
  wire [15:0] w_dat = lk_wr ? {up_rx_data, lo_q} : reg_wdata;      // [R24]
  wire        w_rw  = (w_ptr != 4'h0) && (w_ptr < `DCS_PTR_DIE_ID - 4'h1);
  wire        w_eer = (w_ptr >= `DCS_PTR_EE_FIRST);
  wire        w_reg = w_go & w_rw & ~busy_q & (unlock_q | ~w_eer); // [R15] [R20]
  wire        w_ee  = w_go & w_rw & ~busy_q & unlock_q;            // [R18] [R21]
  wire        cfg_w = w_reg & (w_ptr == `DCS_PTR_CFG);
  wire [15:0] cfg_c = regs_q[1];
  wire        cmd_rst = (st_q == ST_CMD) & up_rx_valid &
                        (up_rx_data == `DCS_CMD_SWRESET);          // [R3]
  wire        soft_rst = cmd_rst | (cfg_w & w_dat[`DCS_CFG_RST_BIT]); // [R3]
  // one-shot only acts in shutdown; continuous schedule untouched
  wire        os_req = cfg_w & w_dat[`DCS_CFG_OS_BIT] &
                       cfg_c[`DCS_CFG_SD_BIT];                     // [R11] [R26]
  // mode or rate change aborts the ongoing conversion
  wire        restart = cfg_w & ({w_dat[15:13], w_dat[11]} !=
                                 {cfg_c[15:13], cfg_c[11]});

  // ----------------------------------------------------------------
  // register and eeprom entries
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 1; gi <= 13; gi = gi + 1) begin : g_ent
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          regs_q[gi] <= 16'h0000;
          ee_q[gi]   <= (gi == 1) ? `DCS_CFG_RST_VAL : 16'h0000;
        end else begin
          if (load_q) begin
            regs_q[gi] <= ee_q[gi];                                // [R14] [R13]
          end else if (w_reg && w_ptr == gi) begin
            regs_q[gi] <= w_dat;
          end
          if (w_ee && w_ptr == gi) begin
            ee_q[gi] <= w_dat;                                     // [R18]
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // temperature, flags, lock and reload
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      temp_q   <= 14'h0000;
      alert_q  <= 4'h0;
      unlock_q <= 1'b0;                                            // [R15]
      load_q   <= 1'b1;                                            // [R14]
    end else begin
      load_q <= soft_rst;                                          // [R3]
      if (load_q) begin
        temp_q  <= 14'h0000;                                       // [R3]
        alert_q <= 4'h0;
      end else if (conv_done) begin
        temp_q  <= temp_sample;                                    // [R9]
        alert_q <= alert_flags;                                    // [R9]
      end
      if (w_go && w_ptr == `DCS_PTR_TEMP) begin
        unlock_q <= w_dat[`DCS_TEMP_UNLOCK_BIT];                   // [R16]
      end
    end
  end

  // programming timer behind the busy bit
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      prog_q <= 22'h000000;
    end else if (w_ee) begin
      busy_q <= 1'b1;                                              // [R19]
      prog_q <= EE_PROG_CYC;                                       // [R18]
    end else if (busy_q) begin
      prog_q <= prog_q - 22'h000001;
      if (prog_q == 22'h000001) begin
        busy_q <= 1'b0;                                            // [R19]
      end
    end
  end

  // ----------------------------------------------------------------
  // host traffic passes on toward the far end
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dn_tx_valid_q <= 1'b0;
      dn_tx_data_q  <= 8'h00;
      fwd_v_q       <= 1'b0;
    end else begin
      dn_tx_valid_q <= up_rx_valid;                                // [R25]
      if (up_rx_valid) begin
        dn_tx_data_q <= up_rx_data;
      end
      fwd_v_q <= (st_q == ST_FWD) & dn_rx_valid;                   // [R25]
    end
  end

  // own byte offered while in a send state
  assign up_tx_valid = fwd_v_q | (st_q == ST_TXLO) | (st_q == ST_TXHI);

  // ----------------------------------------------------------------
  // transaction sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q         <= ST_IDLE;
      cmd_q        <= 8'h00;
      ptr_q        <= 4'h0;
      lo_q         <= 8'h00;
      cnt_q        <= 22'h000000;
      fwd_n_q      <= 6'h00;
      own_after_q  <= 1'b0;
      poll_q       <= 1'b0;
      up_tx_data_q <= 8'h00;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (up_rx_sof) begin
            st_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (up_rx_valid) begin
            cmd_q  <= up_rx_data;
            poll_q <= 1'b0;
            if (!up_rx_data[`DCS_CMD_CMDSEL_BIT]) begin
              st_q <= ST_PTR;                                      // [R23]
            end else if (up_rx_data == `DCS_CMD_POLL && last_at_init) begin
              poll_q <= 1'b1;                                      // [R1]
              cnt_q  <= RSP_CYC;
              st_q   <= ST_WAIT;
            end else if (up_rx_data == `DCS_CMD_POLL) begin
              // not last at init: only relay what comes from below
              fwd_n_q     <= 6'h01;                                // [R2]
              own_after_q <= 1'b0;
              cnt_q       <= TMO_CYC;
              st_q        <= ST_FWD;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_PTR: begin
          if (up_rx_valid) begin
            ptr_q <= up_rx_data[3:0];
            if (!c_read) begin
              st_q <= ST_DLO;
            end else if (c_me) begin
              // stretched reply while an eeprom word is fetched
              cnt_q <= (up_rx_data[3:0] >= `DCS_PTR_EE_FIRST &&
                        up_rx_data[3:0] <= `DCS_PTR_EE_LAST) ?
                       EE_RD_CYC : RSP_CYC;                        // [R22] [R5]
              st_q  <= ST_WAIT;
            end else if (c_blw) begin
              // relay words from beyond; a global read then appends our own
              fwd_n_q     <= c_glob ? {a_diff, 1'b0} : 6'h02;      // [R7]
              own_after_q <= c_glob;                               // [R7]
              cnt_q       <= TMO_CYC;
              st_q        <= ST_FWD;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_DLO: begin
          if (up_rx_valid) begin
            lo_q <= up_rx_data;                                    // [R24]
            st_q <= ST_DHI;
          end
        end
        ST_DHI: begin
          if (up_rx_valid) begin
            st_q <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (cnt_q <= 22'h000001) begin
            up_tx_data_q <= poll_q ? {my_addr, 3'h0} : p_val[7:0];
            st_q         <= ST_TXLO;                               // [R5]
          end else begin
            cnt_q <= cnt_q - 22'h000001;
          end
        end
        ST_TXLO: begin
          if (up_tx_ready) begin
            up_tx_data_q <= p_val[15:8];                           // [R24]
            st_q         <= poll_q ? ST_IDLE : ST_TXHI;            // [R1]
          end
        end
        ST_TXHI: begin
          if (up_tx_ready) begin
            st_q <= ST_IDLE;
          end
        end
        ST_FWD: begin
          if (dn_rx_valid) begin
            up_tx_data_q <= dn_rx_data;                            // [R25]
            cnt_q        <= TMO_CYC;
            fwd_n_q      <= fwd_n_q - 6'h01;
            if (fwd_n_q == 6'h01) begin
              cnt_q <= RSP_CYC;
              st_q  <= own_after_q ? ST_WAIT : ST_IDLE;            // [R7]
            end
          end else if (cnt_q == 22'h000000) begin
            st_q <= ST_IDLE;                                       // [R8]
          end else begin
            cnt_q <= cnt_q - 22'h000001;                           // [R8]
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // local register port: data valid only the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 16'h0000;
    end else begin
      reg_rdata_q <= reg_rd ? rd_val(reg_addr) : 16'h0000;         // [R10]
    end
  end

  // ----------------------------------------------------------------
  // conversion scheduler
  // ----------------------------------------------------------------
  dcs_conv #(
    .CONV_CYC (CONV_CYC)
  ) u_conv (
    .clk      (clk),
    .rstn     (rstn),
    .shutdown (cfg_c[`DCS_CFG_SD_BIT]),                            // [R10]
    .one_shot (os_req),                                            // [R11]
    .restart  (restart | load_q),
    .done_q   (conv_done),                                         // [R9]
    .active   (conv_active)
  );
endmodule // dcs_ops
`default_nettype wire

// File: verification/dcs_ops_properties.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// port checks of the sensor operations block
// --------
module dcs_ops_properties #(
  parameter [15:0] DIE_ID = 16'h1234  // arbitrary value
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata_q,
  input wire logic        up_rx_valid,
  input wire logic [7:0]  up_rx_data,
  input wire logic        dn_tx_valid_q,
  input wire logic [7:0]  dn_tx_data_q,
  input wire logic        dn_rx_valid,
  input wire logic        up_tx_valid,
  input wire logic        up_tx_ready,
  input wire logic [7:0]  up_tx_data_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic unl_q;  // mirror of the unlock flag
  // follows port writes to the unlock flag
  always @(posedge clk or negedge rstn) begin
    if (!rstn) unl_q <= 1'b0;
    else if (reg_wr && reg_addr == 4'h0) unl_q <= reg_wdata[0];
  end
  // unlocked write to a general word, then a status read
  sequence s_prog_wr;
    reg_wr && unl_q && reg_addr >= 4'h6 && reg_addr <= 4'hd;
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == 4'h0;
  endsequence
  a_busy_after_prog: assert property (s_prog_wr ##2 s_stat_rd |=> reg_rdata_q[1])
    else $error("busy flag low after unlocked write");
  a_os_reads_zero: assert property (reg_rd && reg_addr == 4'h1 |=> !reg_rdata_q[12])
    else $error("one-shot bit read as one");
  a_die_id_read: assert property (reg_rd && reg_addr == 4'hf |=> reg_rdata_q == DIE_ID)
    else $error("die id wrong");
  a_unlock_flag: assert property (s_stat_rd |=> reg_rdata_q[0] == unl_q)
    else $error("unlock flag wrong");
  a_relay_down: assert property (up_rx_valid |=> dn_tx_valid_q && dn_tx_data_q == $past(up_rx_data))
    else $error("byte not passed downstream");
  a_relay_quiet: assert property (!up_rx_valid |=> !dn_tx_valid_q)
    else $error("spurious downstream byte");
  a_own_hold: assert property (up_tx_valid && !up_tx_ready && !$past(dn_rx_valid)
    |=> up_tx_valid && $stable(up_tx_data_q)) else $error("reply byte dropped before ready");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
    else $error("read data outside read cycle");
endmodule // dcs_ops_properties
bind dcs_ops dcs_ops_properties #(.DIE_ID(DIE_ID)) u_props (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata_q, .up_rx_valid, .up_rx_data, .dn_tx_valid_q, .dn_tx_data_q, .dn_rx_valid,
  .up_tx_valid, .up_tx_ready, .up_tx_data_q);
`default_nettype wire

// File: verification/dcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// host controller at the upstream end of the chain
// --------
module dcs_host (
  input  wire logic       clk,
  output var  logic       up_rx_sof,
  output var  logic       up_rx_valid,
  output var  logic [7:0] up_rx_data,
  output var  logic       up_tx_ready,
  input  wire logic       up_tx_valid,
  input  wire logic [7:0] up_tx_data_q
);
  logic slow = 1'b0;  // stalls the reply path when set
  initial begin
    up_rx_sof = 1'b0;
    up_rx_valid = 1'b0;
    up_rx_data = 8'h00;
    up_tx_ready = 1'b0;
  end
  // one byte; the released line shows the inverse
  task put(input logic [7:0] b);
    @(posedge clk);
    up_rx_valid <= 1'b1;
    up_rx_data <= b;
    @(posedge clk);
    up_rx_valid <= 1'b0;
    up_rx_data <= ~b;
  endtask
  // command, pointer, then data low byte first
  task frame(input logic [7:0] c, input int n = 1, input logic [7:0] p = 8'h00, input logic [15:0] d = 16'h0000);
    @(posedge clk);
    up_rx_sof <= 1'b1;
    @(posedge clk);
    up_rx_sof <= 1'b0;
    put(c);
    if (n > 1) put(p);
    if (n > 2) put(d[7:0]);
    if (n > 2) put(d[15:8]);
  endtask
  // takes one reply byte; lat stays -1 when the line keeps silent
  task get(output logic [7:0] b, output int lat, input int lim);
    b = 8'h00;
    lat = -1;
    for (int i = 0; i < lim && lat < 0; i++) begin
      @(posedge clk);
      if (up_tx_valid === 1'b1 && up_tx_ready === 1'b1) begin
        b = up_tx_data_q;
        lat = i;
        up_tx_ready <= 1'b0;
      end else up_tx_ready <= slow ? ~up_tx_ready : 1'b1;
    end
  endtask
endmodule // dcs_host
`default_nettype wire

// File: verification/dcs_ops_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.vh"
// --------
// testbench of the sensor operations block
// --------
module dcs_ops_tb_top;
  localparam int RSP = 4, EEP = 40, TMO = 60, CONV = 30;
  localparam logic [15:0] DIE = 16'h1234;  // arbitrary value
  logic clk = 1'b0, rstn = 1'b0, last_q = 1'b1, dn_v = 1'b0, we = 1'b0, re = 1'b0;
  logic [4:0] my = 5'd3;
  logic [7:0] dn_d = 8'h00, b, b2;
  logic [13:0] ts = 14'h0000;
  logic [3:0] af = 4'h0, ra = 4'h0;
  logic [15:0] wd = 16'h0000, v, x, y;
  wire sof, rxv, rdy, txv, dtv, act;
  wire [7:0] rxd, txd, dtd;
  wire [15:0] rdq;
  int error_cnt = 0, n_tests = 0, seed = 22298, lat;
  always #5 clk = ~clk;
  dcs_ops #(.EE_PROG_CYC(22'd40), .TMO_CYC(22'd60), .EE_RD_CYC(22'd20), .RSP_CYC(22'd4), .CONV_CYC(24'd30),
    .DIE_ID(DIE)) dut (.clk(clk), .rstn(rstn), .my_addr(my), .last_at_init(last_q), .up_rx_sof(sof),
    .up_rx_valid(rxv), .up_rx_data(rxd), .up_tx_ready(rdy), .up_tx_valid(txv), .up_tx_data_q(txd),
    .dn_rx_valid(dn_v), .dn_rx_data(dn_d), .dn_tx_valid_q(dtv), .dn_tx_data_q(dtd), .temp_sample(ts),
    .alert_flags(af), .reg_addr(ra), .reg_wdata(wd), .reg_wr(we), .reg_rd(re), .reg_rdata_q(rdq),
    .conv_active(act));
  dcs_host host (.clk(clk), .up_rx_sof(sof), .up_rx_valid(rxv), .up_rx_data(rxd), .up_tx_ready(rdy),
    .up_tx_valid(txv), .up_tx_data_q(txd));
  function automatic logic [7:0] cmd(input logic [4:0] a, input logic g, input logic r);
    return {a, 1'b0, r, g};
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    re <= 1'b1;
    ra <= a;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    v = rdq;
  endtask
  // one byte arriving from the sensors further down
  task dn_byte(input logic [7:0] d);
    @(posedge clk);
    dn_v <= 1'b1;
    dn_d <= d;
    @(posedge clk);
    dn_v <= 1'b0;
    dn_d <= ~d;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog for a hung run
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end
  // main sequence
  initial begin
    ts = 14'($random(seed));
    af = 4'($random(seed));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h1); chk(v, `DCS_CFG_RST_VAL);
    rd(4'h0); chk(v, 16'h0000);
    wr(4'he, 16'($random(seed)));
    rd(4'hf); chk(v, DIE);
    for (int p = 6; p <= 13; p++) begin
      rd(4'(p)); chk(v, 16'h0000);
    end
    $display("end reset values");
    repeat (CONV + 5) @(posedge clk);
    rd(4'h0); chk(v[15:2], 16'(ts));
    rd(4'h1); chk({v[10], v[9], v[6], v[5]}, 16'(af));
    wr(4'h1, 16'ha800);
    y = 16'(ts);
    ts <= 14'($random(seed));
    repeat (CONV + 5) @(posedge clk);
    chk(act, 1'b0);
    rd(4'h0); chk(v[15:2], y);
    wr(4'h1, 16'hb800);
    rd(4'h1); chk(v[12:11], 2'b01);
    repeat (CONV + 5) @(posedge clk);
    chk(act, 1'b0);
    rd(4'h0); chk(v[15:2], 16'(ts));
    wr(4'h1, 16'ha000);
    wr(4'h1, 16'hb000);
    chk(act, 1'b1);
    $display("end conversion modes");
    wr(4'h6, 16'($random(seed)));
    rd(4'h6); chk(v, 16'h0000);
    wr(4'h0, 16'h0001);
    rd(4'h0); chk(v[0], 1'b1);
    x = 16'($random(seed));
    wr(4'h7, x);
    rd(4'h0); chk(v[1], 1'b1);
    wr(4'h2, 16'hbeef);
    repeat (EEP + 5) @(posedge clk);
    rd(4'h0); chk(v[1], 1'b0);
    rd(4'h2); chk(v, 16'h0000);
    wr(4'h0, 16'h0000);
    rd(4'h7); chk(v, x);
    for (int m = 0; m < 2; m++) begin
      wr(4'h2, 16'($random(seed)));
      if (m == 0) host.frame(`DCS_CMD_SWRESET);
      else wr(4'h1, 16'ha002);
      rd(4'h2); chk(v, 16'h0000);
      rd(4'h0); chk(v & 16'hfffc, 16'h0000);
      rd(4'h7); chk(v, x);
    end
    $display("end eeprom");
    y = 16'($random(seed));
    host.frame(cmd(my, 1'b0, 1'b0), 4, 8'h03, y);
    host.frame(cmd(my + 5'd1, 1'b0, 1'b0), 4, 8'h04, y);
    host.frame(cmd(my, 1'b1, 1'b0), 4, 8'h05, ~y);
    host.frame(cmd(my - 5'd1, 1'b1, 1'b0), 4, 8'h04, y);
    rd(4'h3); chk(v, y);
    rd(4'h4); chk(v, 16'h0000);
    rd(4'h5); chk(v, ~y);
    for (int s = 1; s >= 0; s--) begin
      host.slow = s[0];
      host.frame(cmd(my, 1'b0, 1'b1), 2, 8'h03);
      host.get(b, lat, 100);
      if (s == 0) chk(lat <= RSP + RSP / 2, 1'b1);
      host.get(b2, lat, 100);
      chk({b2, b}, y);
    end
    host.frame(cmd(my, 1'b0, 1'b1), 2, 8'h07);
    host.get(b, lat, 100);
    chk(lat > RSP + RSP / 2, 1'b1);
    host.get(b2, lat, 100);
    chk({b2, b}, x);
    host.frame(cmd(my + 5'd1, 1'b1, 1'b1), 2, 8'h03);
    fork
      begin dn_byte(8'h5a); dn_byte(8'ha6); end
      begin host.get(b, lat, 60); host.get(b2, lat, 60); end
    join
    chk({b2, b}, 16'ha65a);
    host.get(b, lat, 100);
    host.get(b2, lat, 100);
    chk({b2, b}, y);
    host.frame(cmd(5'd20, 1'b1, 1'b1), 2, 8'h03);
    host.get(b, lat, TMO + 20);
    chk(lat, -1);
    $display("end link transfers");
    host.frame(`DCS_CMD_POLL);
    host.get(b, lat, 100);
    chk(b, {my, 3'b000});
    last_q <= 1'b0;
    host.frame(`DCS_CMD_POLL);
    fork
      dn_byte(8'h48);
      host.get(b, lat, 60);
    join
    chk(b, 8'h48);
    host.frame(`DCS_CMD_POLL);
    host.get(b, lat, TMO + 20);
    chk(lat, -1);
    $display("end poll");
    print_verdict;
  end
endmodule // dcs_ops_tb_top
`default_nettype wire
